// file: pkg/cmap_defines.svh
// Constants for the configuration management access port.
// Assumes inclusion by bare name from design and bench files.
`ifndef CMAP_DEFINES_SVH
`define CMAP_DEFINES_SVH

`define CMAP_ADDR_W        19
`define CMAP_DATA_W        32
`define CMAP_BE_W          4
`define CMAP_SPACE_BIT     18
`define CMAP_FUNC_HI       17
`define CMAP_FUNC_LO       10
`define CMAP_REG_HI        9
`define CMAP_REG_LO        0
`define CMAP_FUNC_N        2
`define CMAP_CFG_WORDS     64
`define CMAP_MGMT_WORDS    16
`define CMAP_HDR_TYPE_IDX  10'h003
`define CMAP_HDR_TYPE_BIT  16
`define CMAP_HDR1_RO_IDX   10'h006
`define CMAP_HDR1_RO_MASK  32'h000000FF
`define CMAP_RO_MASK_DEF   32'h0000FFFF
`define CMAP_CFG_RST       32'h00000000
`define CMAP_HDR0_RST      32'h00000000
`define CMAP_HDR1_RST      32'h00010000
`define CMAP_LAT           2

`endif

// file: pkg/cmap_pkg.sv
// Types shared by both ends of the configuration management access port.
// Assumes cmap_defines.svh is on the include path.
`include "cmap_defines.svh"
package cmap_pkg;
  typedef logic [`CMAP_ADDR_W-1:0] cmap_addr_t;
  typedef logic [`CMAP_DATA_W-1:0] cmap_data_t;
  typedef logic [`CMAP_BE_W-1:0]   cmap_be_t;
  typedef enum logic { CMAP_MODE_EP, CMAP_MODE_RP } cmap_mode_t;
endpackage

// file: pkg/cmap_if.sv
// Interface joining the user-side requester and the register-space end.
// Assumes both ends share clk_sys; no tristate signals.
`timescale 1ns/1ps
interface cmap_if;
  import cmap_pkg::*;
  cmap_addr_t addr;
  logic       write;
  cmap_data_t write_data;
  cmap_be_t   byte_enable;
  logic       read;
  cmap_data_t read_data;
  logic       done;
  logic       type1_readonly_override;

  modport dev (
    input  addr,
    input  write,
    input  write_data,
    input  byte_enable,
    input  read,
    input  type1_readonly_override,
    output read_data,
    output done
  );
  modport usr (
    output addr,
    output write,
    output write_data,
    output byte_enable,
    output read,
    output type1_readonly_override,
    input  read_data,
    input  done
  );
endinterface

// file: hw/cmap_dev.sv
// Register-space end: configuration and local management words behind a
// strobe/done port. Assumes the requester holds its request until done.
`timescale 1ns/1ps
module cmap_dev (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire cmap_pkg::cmap_mode_t port_mode,
  cmap_if.dev                       bus
);
  import cmap_pkg::*;

  localparam int CFG_AW  = $clog2(`CMAP_CFG_WORDS);
  localparam int MGMT_AW = $clog2(`CMAP_MGMT_WORDS);
  localparam int FUNC_AW = $clog2(`CMAP_FUNC_N);
  // Header type word index cut to the storage index width
  localparam logic [CFG_AW-1:0] HDR_TYPE_CI = CFG_AW'(`CMAP_HDR_TYPE_IDX);

  typedef enum logic [1:0] { ST_IDLE, ST_BUSY, ST_DONE, ST_WAIT } cmap_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  cmap_data_t cfg_mem_r  [`CMAP_FUNC_N][`CMAP_CFG_WORDS];
  cmap_data_t mgmt_mem_r [`CMAP_MGMT_WORDS];

  cmap_state_t state_r, state_nxt;
  logic [1:0]  lat_r, lat_nxt;
  cmap_data_t  rdata_r, rdata_nxt;
  logic        done_r, done_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic                 sel_mgmt;
  logic [7:0]           func_f;
  logic [9:0]           reg_f;
  logic                 in_range;
  logic [FUNC_AW-1:0]   fi;
  logic [CFG_AW-1:0]    ci;
  logic [MGMT_AW-1:0]   mi;
  cmap_data_t           cur_word;
  cmap_data_t           be_mask;
  cmap_data_t           ro_mask;
  cmap_data_t           new_word;
  logic                 is_type1;

  assign sel_mgmt = bus.addr[`CMAP_SPACE_BIT];
  assign func_f   = bus.addr[`CMAP_FUNC_HI:`CMAP_FUNC_LO];
  assign reg_f    = bus.addr[`CMAP_REG_HI:`CMAP_REG_LO];
  assign fi       = func_f[FUNC_AW-1:0];
  assign ci       = reg_f[CFG_AW-1:0];
  assign mi       = reg_f[MGMT_AW-1:0];
  // Holes in the space read as zero and swallow writes
  assign in_range = sel_mgmt ? (reg_f < 10'(`CMAP_MGMT_WORDS))
                             : (func_f < 8'(`CMAP_FUNC_N)) &&
                               (reg_f < 10'(`CMAP_CFG_WORDS));
  assign cur_word = !in_range ? '0 : sel_mgmt ? mgmt_mem_r[mi] : cfg_mem_r[fi][ci];
  assign is_type1 = cfg_mem_r[fi][HDR_TYPE_CI][`CMAP_HDR_TYPE_BIT];

  always_comb begin
    for (int b = 0; b < `CMAP_BE_W; b++) begin
      be_mask[8*b +: 8] = {8{bus.byte_enable[b]}};
    end
    ro_mask = '0;
    if (!sel_mgmt && reg_f == `CMAP_HDR1_RO_IDX) begin
      ro_mask = `CMAP_RO_MASK_DEF;
      // Override only opens read-only bits of a root port type-1 header
      if (port_mode == CMAP_MODE_RP && is_type1 && bus.type1_readonly_override) begin
        ro_mask = ro_mask & ~`CMAP_HDR1_RO_MASK;
      end
    end
    new_word = (cur_word & ~(be_mask & ~ro_mask)) |
               (bus.write_data & be_mask & ~ro_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_nxt = state_r;
    lat_nxt   = lat_r;
    rdata_nxt = rdata_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (bus.read || bus.write) begin
          state_nxt = ST_BUSY;
          lat_nxt   = 2'(`CMAP_LAT - 1);
        end
      end
      ST_BUSY: begin
        if (lat_r != 2'h0) begin
          lat_nxt = lat_r - 2'h1;
        end else begin
          state_nxt = ST_DONE;
          done_nxt  = 1'b1;
          if (bus.read) begin
            rdata_nxt = cur_word;
          end
        end
      end
      // Wait two cycles, ST_DONE then ST_WAIT, for strobes to drop so one request gives one done
      ST_DONE: state_nxt = ST_WAIT;
      ST_WAIT: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      lat_r   <= 2'h0;
      rdata_r <= '0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      lat_r   <= lat_nxt;
      rdata_r <= rdata_nxt;
      done_r  <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register array; write commits with the done cycle
  logic wr_commit;
  assign wr_commit = state_r == ST_BUSY && lat_r == 2'h0 && bus.write && !bus.read;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int f = 0; f < `CMAP_FUNC_N; f++) begin
        for (int w = 0; w < `CMAP_CFG_WORDS; w++) begin
          cfg_mem_r[f][w] <= `CMAP_CFG_RST;
        end
        cfg_mem_r[f][HDR_TYPE_CI] <= (port_mode == CMAP_MODE_RP) ?
                                            `CMAP_HDR1_RST : `CMAP_HDR0_RST;
      end
      for (int w = 0; w < `CMAP_MGMT_WORDS; w++) begin
        mgmt_mem_r[w] <= '0;
      end
    end else if (wr_commit && in_range) begin
      if (sel_mgmt) begin
        mgmt_mem_r[mi] <= new_word;
      end else if (reg_f != `CMAP_HDR_TYPE_IDX) begin
        cfg_mem_r[fi][ci] <= new_word;
      end
    end
  end

  assign bus.read_data = rdata_r;
  assign bus.done      = done_r;
endmodule

// file: hw/cmap_usr.sv
// User end: turns one-shot commands into held strobes on the port and
// returns read data with a completion pulse. Assumes the device ends each
// request with exactly one done pulse.
`timescale 1ns/1ps
module cmap_usr (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 cmd_valid,
  input  wire logic                 cmd_write,
  input  wire cmap_pkg::cmap_addr_t cmd_addr,
  input  wire cmap_pkg::cmap_data_t cmd_wdata,
  input  wire cmap_pkg::cmap_be_t   cmd_be,
  input  wire logic                 cmd_override,
  output logic                      cmd_ready,
  output cmap_pkg::cmap_data_t      rsp_data,
  output logic                      rsp_valid,
  cmap_if.usr                       bus
);
  import cmap_pkg::*;

  typedef enum logic { SU_IDLE, SU_WAIT } cmap_ustate_t;

  cmap_ustate_t state_r, state_nxt;
  cmap_addr_t   addr_r, addr_nxt;
  cmap_data_t   wdata_r, wdata_nxt;
  cmap_be_t     be_r, be_nxt;
  logic         wr_r, wr_nxt;
  logic         rd_r, rd_nxt;
  logic         ovr_r, ovr_nxt;
  cmap_data_t   rsp_data_r, rsp_data_nxt;
  logic         rsp_valid_r, rsp_valid_nxt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    be_nxt        = be_r;
    wr_nxt        = wr_r;
    rd_nxt        = rd_r;
    ovr_nxt       = ovr_r;
    rsp_data_nxt  = rsp_data_r;
    rsp_valid_nxt = 1'b0;
    case (state_r)
      SU_IDLE: begin
        if (cmd_valid) begin
          state_nxt = SU_WAIT;
          addr_nxt  = cmd_addr;
          wdata_nxt = cmd_wdata;
          be_nxt    = cmd_be;
          wr_nxt    = cmd_write;
          rd_nxt    = !cmd_write;
          ovr_nxt   = cmd_override;
        end
      end
      SU_WAIT: begin
        // Everything stays held until done; strobes drop right after
        if (bus.done) begin
          state_nxt     = SU_IDLE;
          wr_nxt        = 1'b0;
          rd_nxt        = 1'b0;
          ovr_nxt       = 1'b0;
          rsp_valid_nxt = 1'b1;
          if (rd_r) begin
            rsp_data_nxt = bus.read_data;
          end
        end
      end
      default: state_nxt = SU_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_r     <= SU_IDLE;
      addr_r      <= '0;
      wdata_r     <= '0;
      be_r        <= '0;
      wr_r        <= 1'b0;
      rd_r        <= 1'b0;
      ovr_r       <= 1'b0;
      rsp_data_r  <= '0;
      rsp_valid_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      be_r        <= be_nxt;
      wr_r        <= wr_nxt;
      rd_r        <= rd_nxt;
      ovr_r       <= ovr_nxt;
      rsp_data_r  <= rsp_data_nxt;
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  assign cmd_ready                   = (state_r == SU_IDLE);
  assign rsp_data                    = rsp_data_r;
  assign rsp_valid                   = rsp_valid_r;
  assign bus.addr                    = addr_r;
  assign bus.write                   = wr_r;
  assign bus.read                    = rd_r;
  assign bus.write_data              = wdata_r;
  assign bus.byte_enable             = be_r;
  assign bus.type1_readonly_override = ovr_r;
endmodule

// file: tb/cmap_chk.sv
// Assertions on the port between the requester and the register-space end.
// Assumes instantiation beside the cmap_if that joins both design ends.
`timescale 1ns/1ps
module cmap_chk (
  input logic                 clk_sys,
  input logic                 rstn,
  input cmap_pkg::cmap_addr_t addr,
  input logic                 write,
  input cmap_pkg::cmap_data_t write_data,
  input cmap_pkg::cmap_be_t   byte_enable,
  input logic                 read,
  input cmap_pkg::cmap_data_t read_data,
  input logic                 done
);
  import cmap_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  wire logic req = read || write;
  //////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $rose(req);
  endsequence
  sequence s_answer;
    !done ##1 !done ##1 done;
  endsequence
  a_done_latency: assert property (s_start |=> s_answer)
    else $error("done not three cycles after strobe");
  a_done_single: assert property (done |=> !done ##1 !done)
    else $error("done longer than one cycle");
  a_rdata_moves: assert property ($changed(read_data) |-> done && read)
    else $error("read data changed outside a read completion");
  // Mid-request reset aborts the attempt, so no false hit on the drop to zero
  a_req_steady: assert property (req && !done |=>
    $stable({addr, write, read, write_data, byte_enable}))
    else $error("request changed before done");
  a_one_strobe: assert property (!(read && write))
    else $error("read and write together");
  a_strobe_drop: assert property (done |=> !req)
    else $error("strobe held after done");
  a_func_unmapped: assert property (done && read && !addr[18] && addr[17:10] >= 8'h02
    |-> read_data == 32'h00000000)
    else $error("unmapped function read not zero");
  a_mgmt_unmapped: assert property (done && read && addr[18] && addr[9:0] >= 10'h010
    |-> read_data == 32'h00000000)
    else $error("unmapped management read not zero");
endmodule

// file: tb/test_config_mgmt_access_port.sv
// Bench driving the requester's command side, with both ends joined.
// Assumes the requester returns one rsp_valid pulse for every command.
`timescale 1ns/1ps
`include "cmap_defines.svh"
`define CHK(nm, e, a) begin \
  num_checks++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, a); \
  end \
end
module test_config_mgmt_access_port;
  import cmap_pkg::*;
  logic       clk_sys, rstn, cmd_valid, cmd_write, cmd_override;
  logic       cmd_ready, rsp_valid;
  cmap_mode_t port_mode;
  cmap_addr_t cmd_addr;
  cmap_data_t cmd_wdata, rsp_data;
  cmap_be_t   cmd_be;
  int         n_fail = 0;
  int         num_checks = 0;
  cmap_if bus ();
  cmap_dev cmap_dev_inst (.clk_sys(clk_sys), .rstn(rstn), .port_mode(port_mode), .bus(bus.dev));
  cmap_usr cmap_usr_inst (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_be(cmd_be),
    .cmd_override(cmd_override), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .bus(bus.usr));
  cmap_chk cmap_chk_inst (.clk_sys(clk_sys), .rstn(rstn), .addr(bus.addr), .write(bus.write),
    .write_data(bus.write_data), .byte_enable(bus.byte_enable), .read(bus.read),
    .read_data(bus.read_data), .done(bus.done));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function automatic cmap_addr_t ad(input logic s, input logic [7:0] f, input logic [9:0] r);
    return {s, f, r};
  endfunction
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask
  task automatic rst(input cmap_mode_t m);
    port_mode = m;
    rstn = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rstn = 1'b1;
    `CHK("reset valid", 1'b0, rsp_valid)
    `CHK("reset data", 32'h00000000, rsp_data)
  endtask
  // Gap after each command covers the end's post-done dead cycles
  task automatic op(input logic w, input cmap_addr_t a, input cmap_data_t d,
                    input cmap_be_t be, input logic ov);
    int n;
    n = 0;
    `CHK("cmd ready", 1'b1, cmd_ready)
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_be = be;
    cmd_override = ov;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1 cmd_valid = 1'b0;
    `CHK("cmd busy", 1'b0, cmd_ready)
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("op done", 1'b1, rsp_valid)
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("rsp pulse", 1'b0, rsp_valid)
  endtask
  task automatic rd(input cmap_addr_t a, input cmap_data_t e);
    op(1'b0, a, 32'h00000000, 4'h0, 1'b0);
    `CHK("read data", e, rsp_data)
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = '0;
    cmd_wdata = '0;
    cmd_be = '0;
    cmd_override = 1'b0;
    rst(CMAP_MODE_EP);
    op(1'b1, ad(0, 0, 10'h010), 32'h12345678, 4'hF, 1'b0);
    rd(ad(0, 0, 10'h010), 32'h12345678);
    for (int i = 0; i < 4; i++) begin
      op(1'b1, ad(0, 0, 10'h020 + 10'(i)), 32'hA5A5A5A5, 4'h1 << i, 1'b0);
      rd(ad(0, 0, 10'h020 + 10'(i)), 32'h000000A5 << (8 * i));
    end
    tdone("byte lanes");
    op(1'b1, ad(0, 1, 10'h010), 32'hCAFEF00D, 4'hF, 1'b0);
    op(1'b1, ad(1, 0, 10'h00F), 32'h0BADBEEF, 4'hF, 1'b0);
    op(1'b1, ad(0, 2, 10'h010), 32'hFFFFFFFF, 4'hF, 1'b0);
    op(1'b1, ad(0, 0, 10'h040), 32'hFFFFFFFF, 4'hF, 1'b0);
    rd(ad(0, 0, 10'h010), 32'h12345678);
    rd(ad(0, 1, 10'h010), 32'hCAFEF00D);
    rd(ad(1, 0, 10'h00F), 32'h0BADBEEF);
    rd(ad(0, 0, 10'h00F), `CMAP_CFG_RST);
    rd(ad(0, 2, 10'h010), 32'h00000000);
    rd(ad(1, 0, 10'h010), 32'h00000000);
    rd(ad(0, 0, 10'h000), `CMAP_CFG_RST);
    rd(ad(0, 0, 10'h040), 32'h00000000);
    tdone("decode");
    rd(ad(0, 0, `CMAP_HDR_TYPE_IDX), `CMAP_HDR0_RST);
    op(1'b1, ad(0, 0, `CMAP_HDR1_RO_IDX), 32'hFFFFFFFF, 4'hF, 1'b1);
    rd(ad(0, 0, `CMAP_HDR1_RO_IDX), ~`CMAP_RO_MASK_DEF);
    rst(CMAP_MODE_RP);
    rd(ad(0, 0, 10'h010), `CMAP_CFG_RST);
    rd(ad(0, 0, `CMAP_HDR_TYPE_IDX), `CMAP_HDR1_RST);
    op(1'b1, ad(0, 0, `CMAP_HDR1_RO_IDX), 32'hFFFFFFFF, 4'hF, 1'b0);
    rd(ad(0, 0, `CMAP_HDR1_RO_IDX), ~`CMAP_RO_MASK_DEF);
    op(1'b1, ad(0, 0, `CMAP_HDR1_RO_IDX), 32'hFFFFFFFF, 4'hF, 1'b1);
    rd(ad(0, 0, `CMAP_HDR1_RO_IDX), ~(`CMAP_RO_MASK_DEF ^ `CMAP_HDR1_RO_MASK));
    op(1'b1, ad(0, 0, 10'h011), 32'hFFFFFFFF, 4'hF, 1'b1);
    rd(ad(0, 0, 10'h011), 32'hFFFFFFFF);
    op(1'b1, ad(0, 1, `CMAP_HDR_TYPE_IDX), 32'h00000000, 4'hF, 1'b0);
    rd(ad(0, 1, `CMAP_HDR_TYPE_IDX), `CMAP_HDR1_RST);
    tdone("override");
    final_report;
  end
  // Whole run needs a few thousand ns; far beyond that means a hang
  initial begin
    #50000;
    `CHK("watchdog", 1'b1, 1'b0)
    final_report;
  end
endmodule
